// >>> src/ddc_rate_and_atten_select.sv
`timescale 1ns/10ps
`default_nettype none
// downconverter bandwidth and attenuator selector with wishbone registers
module ddc_rate_and_atten_select
  import rate_atten_pkg::*;
(
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // wishbone slave
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [3:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  // downconverter controls
  output logic             digital_downconverter_en_o,
  output logic      [2:0]  bw_setting_o,
  output logic      [12:0] decimation_o,
  output logic      [25:0] sample_rate_o,
  output logic      [7:0]  sample_interval_ns_o,
  // attenuator enables, total and busy
  output logic      [2:0]  rf_att_en_o,
  output logic      [1:0]  if_att_en_o,
  output logic      [6:0]  total_att_db_o,
  output logic             busy_o
);
  // picks narrowest setting at least as wide as the request; a request
  // between two graduations coerces upward so no requested band is cut,
  // and anything wider than the widest setting lands on the widest
  function automatic logic [2:0] pick_setting(input logic [31:0] bw);
    logic [2:0] idx;
    idx = 3'h0; // wider than all: widest setting
    // scan widest to narrowest; the last fit is the narrowest one
    for (int i = 0; i < NUM_SETTINGS; i++) begin
      if (bw <= BW_TABLE[i]) begin
        idx = 3'(i);
      end
    end
    return idx;
  endfunction

  // log2 of the decimation factor: 32 at the widest setting, and each
  // narrower setting doubles it; shared by the outputs and the status word
  function automatic logic [3:0] dec_log2(input logic [2:0] setting);
    return 4'(DEC_LOG2_BASE + 4'(setting));
  endfunction

  // host-visible registers, at the package offsets:
  //   bandwidth request, in Hz, any value; coerced at apply time
  //   level pair, reference in the low byte and mixer in the next,
  //   both signed dBm
  //   control, iq mode and the apply strobe, which reads back as
  //   pending until the sequencer has consumed it
  //   status, read only: the applied setting and attenuator result
  // register state
  logic [31:0] bw_req_r,  bw_req_nxt;   // requested bandwidth
  logic [15:0] levels_r,  levels_nxt;   // ref and mixer levels
  logic        iq_r,      iq_nxt;       // iq acquisition mode
  logic        go_r,      go_nxt;       // apply request pending
  logic        ack_r,     ack_nxt;      // bus acknowledge
  logic [31:0] rdat_r,    rdat_nxt;     // read data
  // sequencer and result state; results change only in the two
  // sequencer phases and hold between applies
  seq_state_t  state_r,   state_nxt;
  logic [6:0]  rem_r,     rem_nxt;      // attenuation left for if group
  logic [2:0]  set_r,     set_nxt;      // selected setting
  logic        ddc_r,     ddc_nxt;      // decimation path enable
  logic [2:0]  rf_r,      rf_nxt;       // rf enables
  logic [1:0]  if_r,      if_nxt;       // if enables
  logic [6:0]  rfdb_r,    rfdb_nxt;     // applied rf dB
  logic [6:0]  tot_r,     tot_nxt;      // applied total dB
  // constrained level difference
  logic signed [7:0] ref_lvl;
  logic signed [7:0] mix_lvl;
  logic signed [8:0] diff_raw;
  logic [6:0]        diff_db;
  // attenuator mapper wiring
  logic [6:0]  map_want;
  logic        map_if;
  logic [2:0]  map_en;
  logic [6:0]  map_db;
  // status word built from the held results
  logic [31:0] status_word;

  // one mapper serves both groups; the sequencer phase picks the group
  // and the input, so the rf and if tables can never disagree in timing
  atten_map u_map (
    .want_db_i  (map_want),
    .if_grp_i   (map_if),
    .en_o       (map_en),
    .got_db_i_o (map_db)
  );

  // level difference clamped into 0..50; a mixer level at or above the
  // reference gives no rf attenuation, and the top end is the rf ceiling
  // so the rf group alone always covers the clamped difference
  always_comb begin
    ref_lvl  = $signed(levels_r[LVL_REF_LSB +: 8]);
    mix_lvl  = $signed(levels_r[LVL_MIX_LSB +: 8]);
    // nine bits hold any difference of two signed bytes
    diff_raw = 9'(ref_lvl) - 9'(mix_lvl);
    if (diff_raw <= 9'sh000) begin
      diff_db = 7'h00;
    end else if (diff_raw > 9'(RF_MAX_DB)) begin
      diff_db = RF_MAX_DB;
    end else begin
      diff_db = diff_raw[6:0];
    end
  end

  // mapper shared by both sequencer phases
  // outside the if phase the mapper sees the rf target
  always_comb begin
    map_if   = (state_r == ST_IF);
    map_want = map_if ? rem_r : diff_db;
  end

  // bus slave next state; ack is registered, so a request is taken on
  // the first edge it is seen with ack low and answered one cycle later,
  // and the ack-high cycle itself never counts as a second request
  always_comb begin
    bw_req_nxt = bw_req_r;
    levels_nxt = levels_r;
    iq_nxt     = iq_r;
    go_nxt     = go_r;
    ack_nxt    = 1'b0;
    rdat_nxt   = rdat_r;
    if (state_r == ST_RF) begin
      go_nxt = 1'b0; // request consumed
    end
    if (cyc_i && stb_i && !ack_r) begin
      ack_nxt = 1'b1;
      if (we_i) begin
        case (adr_i)
          OFS_BW_REQ: begin
            for (int b = 0; b < 4; b++) begin
              if (sel_i[b]) bw_req_nxt[b*8 +: 8] = dat_i[b*8 +: 8];
            end
          end
          OFS_LEVELS: begin
            if (sel_i[0]) levels_nxt[7:0]  = dat_i[7:0];
            if (sel_i[1]) levels_nxt[15:8] = dat_i[15:8];
          end
          OFS_CTRL: begin
            if (sel_i[0]) begin
              iq_nxt = dat_i[CTRL_IQ_BIT];
              // overrides the sequencer's clear in the same cycle
              if (dat_i[CTRL_GO_BIT]) go_nxt = 1'b1; // set wins
            end
          end
          default: begin
            // unmapped or read-only: acked, ignored
          end
        endcase
      end else begin
        case (adr_i)
          OFS_BW_REQ: rdat_nxt = bw_req_r;
          OFS_LEVELS: rdat_nxt = {16'h0000, levels_r};
          OFS_CTRL:   rdat_nxt = {30'h0, go_r, iq_r};
          OFS_STATUS: rdat_nxt = status_word;
          default:    rdat_nxt = 32'h0000_0000;
        endcase
      end
    end
  end

  // status word, field by field; spare bits read as zero, and the total
  // is left out because it is on its own output already
  always_comb begin
    status_word                  = 32'h0000_0000;
    status_word[ST_SET_LSB +: 3] = set_r;
    status_word[ST_DEC_LSB +: 4] = dec_log2(set_r);
    status_word[ST_DDC_BIT]      = ddc_r;
    status_word[ST_ATT_LSB +: 5] = {if_r, rf_r};
    status_word[ST_RFD_LSB +: 7] = rfdb_r;
  end

  // configuration sequencer: rf first, then if; the setting, the path
  // enable and the rf enables land one edge after the apply is seen,
  // the if enables and the total one edge later, and busy covers both
  always_comb begin
    state_nxt = state_r;
    rem_nxt   = rem_r;
    set_nxt   = set_r;
    ddc_nxt   = ddc_r;
    rf_nxt    = rf_r;
    if_nxt    = if_r;
    rfdb_nxt  = rfdb_r;
    tot_nxt   = tot_r;
    case (state_r)
      ST_IDLE: begin
        // wait for an apply request
        if (go_r) begin
          state_nxt = ST_RF;
        end
      end
      ST_RF: begin
        // all results of one apply come from one snapshot of the registers
        set_nxt  = pick_setting(bw_req_r);
        ddc_nxt  = iq_r && (bw_req_r < BW_TABLE[0]);
        rf_nxt   = map_en;
        rfdb_nxt = map_db;
        rem_nxt  = 7'h00; // nothing left once rf meets target
        if (diff_db > map_db) begin
          rem_nxt = diff_db - map_db;
        end
        state_nxt = ST_IF;
      end
      ST_IF: begin
        // remainder stays zero while the difference is clamped to 50
        if_nxt    = map_en[1:0];
        tot_nxt   = rfdb_r + map_db;
        state_nxt = ST_IDLE;
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  // bus registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bw_req_r <= BW_REQ_RST;
      levels_r <= LEVELS_RST;
      iq_r     <= 1'b0;
      go_r     <= 1'b0;
      ack_r    <= 1'b0;
      rdat_r   <= 32'h0000_0000;
    end else begin
      bw_req_r <= bw_req_nxt;
      levels_r <= levels_nxt;
      iq_r     <= iq_nxt;
      go_r     <= go_nxt;
      ack_r    <= ack_nxt;
      rdat_r   <= rdat_nxt;
    end
  end

  // sequencer and result registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_r  <= ST_IDLE;
      rem_r    <= 7'h00;
      set_r    <= 3'h0;
      ddc_r    <= 1'b0;
      rf_r     <= 3'h0;
      if_r     <= 2'h0;
      rfdb_r   <= 7'h00;
      tot_r    <= 7'h00;
    end else begin
      state_r  <= state_nxt;
      rem_r    <= rem_nxt;
      set_r    <= set_nxt;
      ddc_r    <= ddc_nxt;
      rf_r     <= rf_nxt;
      if_r     <= if_nxt;
      rfdb_r   <= rfdb_nxt;
      tot_r    <= tot_nxt;
    end
  end

  // outputs, from the bus and result registers, the interval tied to zero; busy also covers an apply
  // that is written but not yet seen, so polling it right after the
  // control write never reads a stale idle
  always_comb begin
    ack_o                      = ack_r;
    dat_o                      = rdat_r;
    digital_downconverter_en_o = ddc_r;
    bw_setting_o               = set_r;
    decimation_o               = 13'(13'h0001 << dec_log2(set_r));
    sample_rate_o              = 26'(IN_RATE_SPS >> dec_log2(set_r));
    // the sample interval runs from 500 ns to 64 us, far past an
    // 8-bit field, so the port is kept and held at zero
    sample_interval_ns_o       = 8'h00;
    rf_att_en_o                = rf_r;
    if_att_en_o                = if_r;
    total_att_db_o             = tot_r;
    busy_o                     = (state_r != ST_IDLE) || go_r;
  end
endmodule
`default_nettype wire

// >>> src/rate_atten_pkg.sv
// constants shared by the rate and attenuator selector
`default_nettype none
package rate_atten_pkg;
  // register byte offsets on the wishbone slave
  localparam logic [3:0] OFS_BW_REQ  = 4'h0; // requested bandwidth, Hz
  localparam logic [3:0] OFS_LEVELS  = 4'h4; // ref level / mixer level, dBm
  localparam logic [3:0] OFS_CTRL    = 4'h8; // mode and apply strobe
  localparam logic [3:0] OFS_STATUS  = 4'hc; // selected result
  // field positions
  localparam int LVL_REF_LSB  = 0;  // reference level, signed 8 bit
  localparam int LVL_MIX_LSB  = 8;  // mixer level, signed 8 bit
  localparam int CTRL_IQ_BIT  = 0;  // 1 = complex iq acquisition
  localparam int CTRL_GO_BIT  = 1;  // write 1 to apply configuration
  localparam int ST_SET_LSB   = 0;  // setting index, 3 bits
  localparam int ST_DEC_LSB   = 4;  // log2 of decimation, 4 bits
  localparam int ST_DDC_BIT   = 8;  // downconverter path enabled
  localparam int ST_ATT_LSB   = 12; // five attenuator enables
  localparam int ST_RFD_LSB   = 20; // applied rf attenuation, dB
  localparam int ST_TOT_LSB   = 27; // unused spare position
  // reset values
  localparam logic [31:0] BW_REQ_RST = 32'h0013_12d0; // 1.25 MHz
  localparam logic [15:0] LEVELS_RST = 16'h0000;
  // bandwidth table, Hz, widest first
  localparam int NUM_SETTINGS = 8;
  localparam logic [31:0] BW_TABLE [NUM_SETTINGS] = '{
    32'h0013_12d0, 32'h000c_3500, 32'h0006_1a80, 32'h0003_0d40,
    32'h0001_86a0, 32'h0000_c350, 32'h0000_61a8, 32'h0000_30d4};
  localparam logic [3:0] DEC_LOG2_BASE = 4'h5; // decimation 32 at index 0
  localparam int IN_RATE_SPS = 64_000_000;    // input sample rate
  // attenuator step sizes, dB
  localparam logic [6:0] RF1_DB = 7'h14;
  localparam logic [6:0] RF2_DB = 7'h14;
  localparam logic [6:0] RF3_DB = 7'h0a;
  localparam logic [6:0] IF1_DB = 7'h14;
  localparam logic [6:0] IF2_DB = 7'h0a;
  localparam logic [6:0] RF_MAX_DB = 7'h32;   // 50 dB rf ceiling
  localparam logic [6:0] IF_MAX_DB = 7'h1e;   // 30 dB if ceiling
  // sequencer states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_RF   = 3'b010,
    ST_IF   = 3'b100
  } seq_state_t;
endpackage
`default_nettype wire

// >>> src/atten_map.sv
`timescale 1ns/10ps
`default_nettype none
// maps a 10 dB quantised attenuation onto rf or if attenuator enables
module atten_map
  import rate_atten_pkg::*;
(
  // request
  input  wire logic [6:0] want_db_i,  // wanted attenuation, dB
  input  wire logic       if_grp_i,   // 1 = if group, 0 = rf group
  // result
  output logic      [2:0] en_o,       // rf {3,2,1} or if {-,2,1}
  output logic      [6:0] got_db_i_o  // attenuation actually applied
);
  // quantise up to 10 dB steps and pick the combination
  always_comb begin
    logic [6:0] q;
    q = 7'h00;
    if (want_db_i > 7'h00) begin
      q = ((want_db_i + 7'h09) / 7'h0a) * 7'h0a;
    end
    en_o = 3'b000;
    got_db_i_o = 7'h00;
    if (!if_grp_i) begin
      if (q > RF_MAX_DB) begin
        q = RF_MAX_DB;
      end
      case (q)
        7'h0a:   en_o = 3'b100; // third
        7'h14:   en_o = 3'b001; // first
        7'h1e:   en_o = 3'b101; // first and third
        7'h28:   en_o = 3'b011; // first and second
        7'h32:   en_o = 3'b111; // all three
        default: en_o = 3'b000; // none
      endcase
      got_db_i_o = (en_o[0] ? RF1_DB : 7'h00) + (en_o[1] ? RF2_DB : 7'h00)
                 + (en_o[2] ? RF3_DB : 7'h00);
    end else begin
      if (q > IF_MAX_DB) begin
        q = IF_MAX_DB;
      end
      case (q)
        7'h0a:   en_o = 3'b010; // second if
        7'h14:   en_o = 3'b001; // first if
        7'h1e:   en_o = 3'b011; // both
        default: en_o = 3'b000;
      endcase
      got_db_i_o = (en_o[0] ? IF1_DB : 7'h00) + (en_o[1] ? IF2_DB : 7'h00);
    end
  end
endmodule
`default_nettype wire

// >>> dv/rate_atten_asserts.sv
// port-level checks for the rate and attenuator selector
`timescale 1ns/10ps
`default_nettype none
module rate_atten_asserts
  import rate_atten_pkg::*;
(
  // clock, reset and bus
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        cyc_i,
  input wire logic        stb_i,
  input wire logic        ack_o,
  // results
  input wire logic        digital_downconverter_en_o,
  input wire logic [2:0]  bw_setting_o,
  input wire logic [12:0] decimation_o,
  input wire logic [25:0] sample_rate_o,
  input wire logic [2:0]  rf_att_en_o,
  input wire logic [1:0]  if_att_en_o,
  input wire logic [6:0]  total_att_db_o,
  input wire logic        busy_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // every taken request is answered on the next edge
  ack_timing_a: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("ack late");
  // ack lasts one cycle only
  ack_pulse_a: assert property (ack_o |=> !ack_o)
    else $error("ack too long");
  // decimation tracks the setting
  dec_map_a: assert property (decimation_o == (13'h20 << bw_setting_o))
    else $error("bad decimation");
  // rate times decimation is the input rate
  rate_map_a: assert property (({13'h0, sample_rate_o} *
    {26'h0, decimation_o}) == 39'h3d09000) else $error("bad rate");
  // rf enables only in tabulated patterns
  rf_table_a: assert property (rf_att_en_o inside {3'h0, 3'h4, 3'h1,
    3'h5, 3'h3, 3'h7}) else $error("bad rf pattern");
  // total is the sum of enabled steps once idle
  total_sum_a: assert property (!busy_o |-> total_att_db_o ==
    (rf_att_en_o[0] ? RF1_DB : 7'h0) + (rf_att_en_o[1] ? RF2_DB : 7'h0) +
    (rf_att_en_o[2] ? RF3_DB : 7'h0) + (if_att_en_o[0] ? IF1_DB : 7'h0) +
    (if_att_en_o[1] ? IF2_DB : 7'h0)) else $error("bad total");
  // results frozen while no request or apply runs
  result_hold_a: assert property (!busy_o && !cyc_i |=>
    $stable(bw_setting_o) && $stable(rf_att_en_o) &&
    $stable(digital_downconverter_en_o)) else $error("result moved");
  // an apply finishes within a few cycles
  apply_done_a: assert property ($rose(busy_o) |-> ##[1:4] !busy_o)
    else $error("apply hung");
  // clamped difference leaves no if remainder
  if_idle_a: assert property (!busy_o |-> if_att_en_o == 2'h0)
    else $error("if enabled");
endmodule
bind ddc_rate_and_atten_select rate_atten_asserts chk (
  .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
  .ack_o(ack_o), .digital_downconverter_en_o(digital_downconverter_en_o),
  .bw_setting_o(bw_setting_o), .decimation_o(decimation_o),
  .sample_rate_o(sample_rate_o), .rf_att_en_o(rf_att_en_o),
  .if_att_en_o(if_att_en_o), .total_att_db_o(total_att_db_o),
  .busy_o(busy_o));
`default_nettype wire

// >>> dv/tb_ddc_rate_and_atten_select.sv
// self-checking bench for the rate and attenuator selector
`timescale 1ns/10ps
`default_nettype none
module tb_ddc_rate_and_atten_select
  import rate_atten_pkg::*;
;
  logic        clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, ddc_o, busy_o;
  logic [3:0]  adr_i, sel_i, lanes;
  logic [31:0] dat_i, dat_o, rd;
  logic [2:0]  set_o, rf_o;
  logic [1:0]  if_o;
  logic [12:0] dec_o;
  logic [25:0] rate_o;
  logic [7:0]  ival_o;
  logic [6:0]  tot_o;
  int          bad_count, cmp_count, seed;
  ddc_rate_and_atten_select dut (.clk_i(clk_i), .rst_i(rst_i),
    .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
    .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .digital_downconverter_en_o(ddc_o), .bw_setting_o(set_o),
    .decimation_o(dec_o), .sample_rate_o(rate_o),
    .sample_interval_ns_o(ival_o), .rf_att_en_o(rf_o),
    .if_att_en_o(if_o), .total_att_db_o(tot_o), .busy_o(busy_o));
  // free-running clock
  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end
  // verdict and end of run
  task automatic conclude;
    if (bad_count == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // compare seen against expected
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  // one classic wishbone cycle
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_i);
    {cyc_i, stb_i, we_i, adr_i, sel_i, dat_i} <= {2'h3, w, a, lanes, d};
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 20);
    rd = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    if (n >= 20) begin bad_count++; conclude(); end
  endtask
  // narrowest setting at least as wide as the request
  function automatic logic [2:0] exp_set(input logic [31:0] bw);
    exp_set = 3'h0;
    for (int i = 0; i < NUM_SETTINGS; i++)
      if (BW_TABLE[i] >= bw) exp_set = i[2:0];
  endfunction
  // clamped difference rounded up to 10 dB
  function automatic int exp_db(input int d);
    exp_db = (d <= 0) ? 0 : (d >= 50) ? 50 : ((d + 9) / 10) * 10;
  endfunction
  // status word expected from the package field positions
  function automatic logic [31:0] exp_status(input logic [2:0] s,
      input logic e, input logic [4:0] att, input logic [6:0] db);
    exp_status = (32'(s) << ST_SET_LSB)
               | (32'(DEC_LOG2_BASE + 4'(s)) << ST_DEC_LSB)
               | (32'(e) << ST_DDC_BIT) | (32'(att) << ST_ATT_LSB)
               | (32'(db) << ST_RFD_LSB);
  endfunction
  // program, apply, wait idle, compare
  task automatic apply(input logic [31:0] bw, input int rl, input int ml,
                       input logic iq);
    int n, d;
    logic [2:0] s, r;
    logic       e;
    wb(1'b1, OFS_BW_REQ, bw);
    wb(1'b1, OFS_LEVELS, {16'h0, ml[7:0], rl[7:0]});
    wb(1'b1, OFS_CTRL, {30'h0, 1'b1, iq});
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (busy_o !== 1'b0 && n < 20);
    if (n >= 20) begin bad_count++; conclude(); end
    s = exp_set(bw);
    d = exp_db(rl - ml);
    r = d == 10 ? 3'h4 : d == 20 ? 3'h1 : d == 30 ? 3'h5 :
        d == 40 ? 3'h3 : d == 50 ? 3'h7 : 3'h0;
    e = iq && bw < 32'h0013_12d0;
    chk(set_o, s);
    chk(dec_o, 13'h20 << s);
    chk(rate_o, 26'h1e8480 >> s);
    chk(ival_o, 8'h00);
    chk(ddc_o, e);
    chk(rf_o, r);
    chk(if_o, 2'h0);
    chk(tot_o, d[6:0]);
    wb(1'b0, OFS_STATUS, 32'h0);
    chk(rd, exp_status(s, e, {2'h0, r}, d[6:0]));
  endtask
  // main sequence
  initial begin
    {cyc_i, stb_i, we_i, adr_i, dat_i} = '0;
    sel_i = 4'hf;
    lanes = 4'hf;
    rst_i = 1'b1;
    bad_count = 0;
    cmp_count = 0;
    seed = 68;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    chk(set_o, 3'h0);
    chk(dec_o, 13'h20);
    chk(rate_o, 26'h1e8480);
    chk(busy_o, 1'b0);
    wb(1'b0, OFS_BW_REQ, 32'h0);
    chk(rd, BW_REQ_RST);
    wb(1'b0, 4'h2, 32'h0);
    chk(rd, 32'h0);
    // one byte lane only, then a write to the read-only status word
    lanes <= 4'h1;
    wb(1'b1, OFS_BW_REQ, 32'haaaa_aa55);
    lanes <= 4'hf;
    wb(1'b0, OFS_BW_REQ, 32'h0);
    chk(rd, {BW_REQ_RST[31:8], 8'h55});
    wb(1'b1, OFS_STATUS, 32'hffff_ffff);
    wb(1'b0, OFS_STATUS, 32'h0);
    chk(rd, exp_status(3'h0, 1'b0, 5'h00, 7'h00));
    // exact settings, then one above each, with level corners
    for (int k = 0; k < NUM_SETTINGS; k++) begin
      apply(BW_TABLE[k], 10 * k - 30, -30, k[0]);
      apply(BW_TABLE[k] + 1, 10 * k - 25, -30, ~k[0]);
    end
    // random requests and levels
    repeat (40) apply($random(seed) & 32'h1f_ffff, $random(seed) % 80,
                      $random(seed) % 80, $random(seed));
    wb(1'b0, OFS_CTRL, 32'h0);
    chk(rd[CTRL_GO_BIT], 1'b0);
    conclude();
  end
endmodule
`default_nettype wire
